// >>> inc/dwm_regs.vh
// Purpose: register offsets, field positions, reset values and warning slots of the
//          drive warning manager.
// Assumes: byte offsets on the plain register port, 32-bit data.
// Notes:   definitions only; included by rtl/dwm_top.v.
`ifndef DWM_REGS_VH
`define DWM_REGS_VH

// ==========================================================================
// register byte offsets
`define DWM_OFF_DEV_LEVEL   8'h00
`define DWM_OFF_DEV_PCT     8'h04
`define DWM_OFF_SON_LEVEL   8'h08
`define DWM_OFF_SON_PCT     8'h0c
`define DWM_OFF_OH_LEVEL    8'h10
`define DWM_OFF_SELECT      8'h14
`define DWM_OFF_CMD_MIN     8'h18
`define DWM_OFF_CMD_MAX     8'h1c
`define DWM_OFF_CLEAR       8'h20
`define DWM_OFF_ACTIVE      8'h24
`define DWM_OFF_CODE        8'h28

// ==========================================================================
// select register fields
`define DWM_SEL_BATT_WARN   0
`define DWM_SEL_DETECT_EN   1
`define DWM_SEL_VIB_WARN    2
`define DWM_SEL_FAN_EN      3
`define DWM_SEL_RIPPLE_EN   4
`define DWM_SEL_CHECK_MASK  5
`define DWM_SEL_OT_EN       6
`define DWM_SEL_MAINT_EN    7
`define DWM_SEL_CODE_BOTH   8
`define DWM_SEL_LEGACY      9
`define DWM_SEL_WIDTH       10
`define DWM_CODE_VALID_BIT  12

// ==========================================================================
// reset values
`define DWM_RST_LEVEL       32'hffffffff
`define DWM_RST_PCT         16'h0064
`define DWM_RST_OH_LEVEL    16'hffff
`define DWM_RST_SELECT      10'h10b
`define DWM_RST_CMD_MIN     32'h00000000
`define DWM_RST_CMD_MAX     32'hffffffff
`define DWM_PERCENT_DIV     32'h00000064

// ==========================================================================
// warning slots, ascending code order; masks over the 27 slots
`define DWM_NW              27
`define DWM_AUTO_MASK       27'h1bef000
`define DWM_CHECK_MASK_SET  27'h1fff000

`endif

// >>> rtl/dwm_top.v
// Purpose: warning detection, latching, clearing and code reporting of a servo drive.
// Assumes: condition inputs other than pins come from logic on clk_i; pins are synchronised.
// Notes:   registers on a plain port, read data one cycle after the read strobe.
//
// The placing of the registers and the strobed register port are this design's own decisions.
`include "dwm_regs.vh"
`default_nettype none

module dwm_top (
  // clock and reset
  input  wire        clk_i,
  input  wire        rst_n_i,
  // register port
  input  wire [7:0]  addr_i,
  input  wire [31:0] wdata_i,
  input  wire        we_i,
  input  wire        re_i,
  output reg  [31:0] rdata_o,
  // motion state (same clock)
  input  wire [31:0] deviation_i,
  input  wire        servo_on_i,
  input  wire        overload_pre_i,
  input  wire        regen_pre_i,
  input  wire        dbrake_pre_i,
  input  wire        vib_detect_i,
  input  wire [15:0] overheat_protection_input_i,
  input  wire [31:0] enc_ripple_i,
  input  wire [31:0] drv_ripple_i,
  input  wire        ripple_valid_i,
  // asynchronous pins
  input  wire        ctrl_temp_bad_i,
  input  wire        power_temp_bad_i,
  input  wire        fan_stopped_i,
  input  wire        battery_low_i,
  input  wire        overtravel_i,
  input  wire        part_life_end_i,
  // network command checks (one-cycle pulses)
  input  wire        err_param_num_i,
  input  wire        err_range_i,
  input  wire        err_calc_i,
  input  wire        err_size_i,
  input  wire        err_latch_mode_i,
  input  wire        cmd_unmet_i,
  input  wire        cmd_unsupported_i,
  input  wire        cmd_latch_interf_i,
  input  wire        cmd_sub_conflict_i,
  input  wire        cmd_undefined_i,
  input  wire        cmd_phase_err_i,
  input  wire        link_error_i,
  input  wire        cmd_ok_i,
  input  wire        clear_fault_i,
  // command data clamp
  input  wire [31:0] cmd_data_i,
  input  wire        cmd_data_valid_i,
  output reg  [31:0] clamped_data_o,
  output reg         clamped_valid_o,
  // warning report
  output reg  [11:0] warn_code_o,
  output reg         warn_code_valid_o,
  output wire        warn_any_o,
  output reg         battery_alarm_o,
  output reg         vibration_alarm_o
);

  localparam NW = `DWM_NW;
  localparam NS = 6;

  // ========================================================================
  // decoding used by the code report
  function [11:0] slot_code;
    input [4:0] idx;
    begin
      case (idx)
        5'd0:    slot_code = 12'h900;
        5'd1:    slot_code = 12'h901;
        5'd2:    slot_code = 12'h910;
        5'd3:    slot_code = 12'h911;
        5'd4:    slot_code = 12'h912;
        5'd5:    slot_code = 12'h913;
        5'd6:    slot_code = 12'h920;
        5'd7:    slot_code = 12'h921;
        5'd8:    slot_code = 12'h923;
        5'd9:    slot_code = 12'h930;
        5'd10:   slot_code = 12'h93b;
        5'd11:   slot_code = 12'h942;
        5'd12:   slot_code = 12'h94a;
        5'd13:   slot_code = 12'h94b;
        5'd14:   slot_code = 12'h94c;
        5'd15:   slot_code = 12'h94d;
        5'd16:   slot_code = 12'h94e;
        5'd17:   slot_code = 12'h95a;
        5'd18:   slot_code = 12'h95b;
        5'd19:   slot_code = 12'h95d;
        5'd20:   slot_code = 12'h95e;
        5'd21:   slot_code = 12'h95f;
        5'd22:   slot_code = 12'h960;
        5'd23:   slot_code = 12'h97a;
        5'd24:   slot_code = 12'h97b;
        5'd25:   slot_code = 12'h9a0;
        5'd26:   slot_code = 12'h9b0;
        default: slot_code = 12'h000;
      endcase
    end
  endfunction

  // lowest set slot; slots are in ascending code order
  function [4:0] lowest_slot;
    input [NW-1:0] v;
    integer k;
    begin
      lowest_slot = 5'd0;
      for (k = NW - 1; k >= 0; k = k - 1) begin
        if (v[k]) begin
          lowest_slot = k[4:0];
        end
      end
    end
  endfunction

  // ========================================================================
  // pin synchronisers
  wire [NS-1:0] pin_raw = {part_life_end_i, overtravel_i, battery_low_i,
                           fan_stopped_i, power_temp_bad_i, ctrl_temp_bad_i};
  reg  [NS-1:0] pin_meta;
  reg  [NS-1:0] pin_sync;

  genvar g;
  generate
    for (g = 0; g < NS; g = g + 1) begin : g_sync
      // two stages; only the second stage is read by the logic
      always @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          pin_meta[g] <= 1'b0;
          pin_sync[g] <= 1'b0;
        end else begin
          pin_meta[g] <= pin_raw[g];
          pin_sync[g] <= pin_meta[g];
        end
      end
    end
  endgenerate

  wire ctrl_temp_s = pin_sync[0];
  wire power_temp_s = pin_sync[1];
  wire fan_stop_s = pin_sync[2];
  wire batt_low_s = pin_sync[3];
  wire ot_s = pin_sync[4];
  wire life_end_s = pin_sync[5];

  // ========================================================================
  // settings registers
  reg [31:0]               deviation_alarm_level;
  reg [15:0]               deviation_warning_percent;
  reg [31:0]               servo_on_deviation_level;
  reg [15:0]               servo_on_deviation_percent;
  reg [15:0]               overheat_warning_level;
  reg [`DWM_SEL_WIDTH-1:0] sel;
  reg [31:0]               cmd_min;
  reg [31:0]               cmd_max;
  reg [NW-1:0]             active;

  wire wr_clear = we_i && (addr_i == `DWM_OFF_CLEAR) && wdata_i[0];

  // software writes; the clear register is a write-one strobe, not stored
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      deviation_alarm_level      <= `DWM_RST_LEVEL;
      deviation_warning_percent  <= `DWM_RST_PCT;
      servo_on_deviation_level   <= `DWM_RST_LEVEL;
      servo_on_deviation_percent <= `DWM_RST_PCT;
      overheat_warning_level     <= `DWM_RST_OH_LEVEL;
      sel                        <= `DWM_RST_SELECT;
      cmd_min                    <= `DWM_RST_CMD_MIN;
      cmd_max                    <= `DWM_RST_CMD_MAX;
    end else if (we_i) begin
      case (addr_i)
        `DWM_OFF_DEV_LEVEL: deviation_alarm_level      <= wdata_i;
        `DWM_OFF_DEV_PCT:   deviation_warning_percent  <= wdata_i[15:0];
        `DWM_OFF_SON_LEVEL: servo_on_deviation_level   <= wdata_i;
        `DWM_OFF_SON_PCT:   servo_on_deviation_percent <= wdata_i[15:0];
        `DWM_OFF_OH_LEVEL:  overheat_warning_level     <= wdata_i[15:0];
        `DWM_OFF_SELECT:    sel                        <= wdata_i[`DWM_SEL_WIDTH-1:0];
        `DWM_OFF_CMD_MIN:   cmd_min                    <= wdata_i;
        `DWM_OFF_CMD_MAX:   cmd_max                    <= wdata_i;
        default: ;
      endcase
    end
  end

  // read data in the cycle after the strobe only; unmapped reads give zero
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_o <= 32'h00000000;
    end else if (re_i) begin
      case (addr_i)
        `DWM_OFF_DEV_LEVEL: rdata_o <= deviation_alarm_level;
        `DWM_OFF_DEV_PCT:   rdata_o <= {16'h0000, deviation_warning_percent};
        `DWM_OFF_SON_LEVEL: rdata_o <= servo_on_deviation_level;
        `DWM_OFF_SON_PCT:   rdata_o <= {16'h0000, servo_on_deviation_percent};
        `DWM_OFF_OH_LEVEL:  rdata_o <= {16'h0000, overheat_warning_level};
        `DWM_OFF_SELECT:    rdata_o <= {22'h000000, sel};
        `DWM_OFF_CMD_MIN:   rdata_o <= cmd_min;
        `DWM_OFF_CMD_MAX:   rdata_o <= cmd_max;
        `DWM_OFF_ACTIVE:    rdata_o <= {5'h00, active};
        `DWM_OFF_CODE:      rdata_o <= {19'h00000, warn_code_valid_o, warn_code_o};
        default:            rdata_o <= 32'h00000000;
      endcase
    end else begin
      rdata_o <= 32'h00000000;
    end
  end

  // ========================================================================
  // threshold compares; both sides scaled by 100 so no divider is needed
  wire [47:0] dev_x100 = {16'h0000, deviation_i} * `DWM_PERCENT_DIV;
  wire [47:0] dev_lim  = {16'h0000, deviation_alarm_level} *
                         {32'h00000000, deviation_warning_percent};
  wire [47:0] son_lim  = {16'h0000, servo_on_deviation_level} *
                         {32'h00000000, servo_on_deviation_percent};

  reg servo_on_q;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      servo_on_q <= 1'b0;
    end else begin
      servo_on_q <= servo_on_i;
    end
  end
  wire servo_on_rise = servo_on_i & ~servo_on_q;

  // ========================================================================
  // command data clamp
  wire below_min = cmd_data_i < cmd_min;
  wire above_max = cmd_data_i > cmd_max;
  wire clamp_hit = cmd_data_valid_i & (below_min | above_max);

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      clamped_data_o  <= 32'h00000000;
      clamped_valid_o <= 1'b0;
    end else begin
      clamped_valid_o <= cmd_data_valid_i;
      if (cmd_data_valid_i) begin
        if (below_min) begin
          clamped_data_o <= cmd_min;
        end else if (above_max) begin
          clamped_data_o <= cmd_max;
        end else begin
          clamped_data_o <= cmd_data_i;
        end
      end
    end
  end

  // ========================================================================
  // detection with enables
  wire gen   = sel[`DWM_SEL_DETECT_EN];
  wire chk   = gen & ~sel[`DWM_SEL_CHECK_MASK];
  reg  [NW-1:0] raise;

  always @* begin
    raise     = {NW{1'b0}};
    raise[0]  = gen & (dev_x100 > dev_lim);
    raise[1]  = gen & servo_on_rise & (dev_x100 > son_lim);
    raise[2]  = gen & overload_pre_i;
    raise[3]  = gen & sel[`DWM_SEL_VIB_WARN] & vib_detect_i;
    raise[4]  = gen & ctrl_temp_s;
    raise[5]  = gen & power_temp_s;
    raise[6]  = gen & regen_pre_i;
    raise[7]  = gen & dbrake_pre_i;
    raise[8]  = sel[`DWM_SEL_FAN_EN] & fan_stop_s;
    raise[9]  = gen & sel[`DWM_SEL_BATT_WARN] & batt_low_s;
    raise[10] = gen & (overheat_protection_input_i > overheat_warning_level);
    raise[11] = gen & sel[`DWM_SEL_RIPPLE_EN] & ripple_valid_i &
                (enc_ripple_i != drv_ripple_i);
    raise[12] = chk & err_param_num_i;
    raise[13] = chk & err_range_i;
    raise[14] = chk & err_calc_i;
    raise[15] = chk & err_size_i;
    raise[16] = chk & err_latch_mode_i;
    raise[17] = chk & cmd_unmet_i;
    raise[18] = chk & cmd_unsupported_i;
    raise[19] = chk & cmd_latch_interf_i;
    raise[20] = chk & cmd_sub_conflict_i;
    raise[21] = chk & cmd_undefined_i;
    raise[22] = chk & link_error_i;
    raise[23] = chk & cmd_phase_err_i;
    raise[24] = chk & clamp_hit;
    raise[25] = sel[`DWM_SEL_OT_EN] & servo_on_i & ot_s;
    raise[26] = gen & sel[`DWM_SEL_MAINT_EN] & life_end_s;
  end

  // ========================================================================
  // clearing: latched slots need clear fault; auto slots follow the profile
  wire clr_fault = clear_fault_i | wr_clear;
  wire clr_auto  = sel[`DWM_SEL_LEGACY] ? clr_fault : (cmd_ok_i | clr_fault);
  wire [NW-1:0] auto_mask = `DWM_AUTO_MASK;
  wire [NW-1:0] clr_vec   = (auto_mask & {NW{clr_auto}}) |
                            (~auto_mask & {NW{clr_fault}});

  // a raise in the clearing cycle wins, so no event is lost
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      active <= {NW{1'b0}};
    end else begin
      active <= raise | (active & ~clr_vec);
    end
  end

  // alarm-mode routing of vibration and battery conditions
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      battery_alarm_o   <= 1'b0;
      vibration_alarm_o <= 1'b0;
    end else begin
      battery_alarm_o   <= batt_low_s & ~sel[`DWM_SEL_BATT_WARN];
      vibration_alarm_o <= vib_detect_i & ~sel[`DWM_SEL_VIB_WARN];
    end
  end

  // ========================================================================
  // code report: lowest active slot, only when codes are enabled for output
  wire code_en = sel[`DWM_SEL_CODE_BOTH] & (|active);

  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      warn_code_o       <= 12'h000;
      warn_code_valid_o <= 1'b0;
    end else begin
      warn_code_valid_o <= code_en;
      warn_code_o       <= code_en ? slot_code(lowest_slot(active)) : 12'h000;
    end
  end

  assign warn_any_o = |active;

endmodule // dwm_top

`default_nettype wire

// >>> sim/dwm_host.sv
// Purpose: host motion controller model on the network side of the warning manager.
// Assumes: the bench requests one command at a time.
// Notes:   each request becomes a one-cycle check pulse, like a decoded network frame.
`default_nettype none

// ==========================================================================
// host model
module dwm_host (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  // request from the bench
  input wire logic [3:0]  op_i,
  input wire logic        go_i,
  // decoded checks: 0-11 faults, 12 correct command, 13 clear fault
  output var logic [13:0] pulse_o
);
  // pulse for each cycle that go_i is high, cleared the cycle after, so a one-cycle request repeats no fault or clear
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pulse_o <= 14'h0000;
    end else if (go_i) begin
      pulse_o <= 14'h0001 << op_i;
    end else begin
      pulse_o <= 14'h0000;
    end
  end
endmodule // dwm_host
`default_nettype wire

// >>> sim/dwm_properties.sv
// Purpose: concurrent checks on the ports of the drive warning manager.
// Assumes: one clock domain, reset asynchronous and active low.
// Notes:   sees only top-level ports; bound from the bench top file.
`default_nettype none

// ==========================================================================
// port checker
module dwm_chk (
  // clock and reset
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  // register port and host commands
  input wire logic [7:0]  addr_i,
  input wire logic        we_i,
  input wire logic        cmd_ok_i,
  input wire logic        clear_fault_i,
  // command data clamp
  input wire logic [31:0] cmd_data_i,
  input wire logic        cmd_data_valid_i,
  input wire logic [31:0] clamped_data_o,
  input wire logic        clamped_valid_o,
  // warning report
  input wire logic [11:0] warn_code_o,
  input wire logic        warn_code_valid_o,
  input wire logic        warn_any_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  // any source that may legally drop a warning this cycle; latched ones must stay otherwise
  logic clr_any;
  assign clr_any = cmd_ok_i | clear_fault_i | (we_i & (addr_i == 8'h20));

  // clamp request and its answer
  sequence s_clamp_req;
    cmd_data_valid_i;
  endsequence
  sequence s_clamp_ans;
    clamped_valid_o;
  endsequence

  a_clamp_answer: assert property (s_clamp_req |=> s_clamp_ans)
    else $error("clamped data not answered one cycle after command data");
  a_clamp_quiet: assert property (!cmd_data_valid_i |=> !clamped_valid_o)
    else $error("clamped valid without command data");
  a_clamp_hold: assert property (!cmd_data_valid_i |=> $stable(clamped_data_o))
    else $error("clamped data moved without command data");
  a_latch_hold: assert property (warn_any_o && !clr_any |=> warn_any_o)
    else $error("warning dropped without any clear source");
  a_idle_novalid: assert property (!warn_any_o |=> !warn_code_valid_o)
    else $error("code valid with no active warning");
  a_valid_source: assert property (warn_code_valid_o |-> $past(warn_any_o))
    else $error("code valid not preceded by an active warning");
  a_code_range: assert property (warn_code_valid_o |->
    warn_code_o inside {[12'h900:12'h9b0]})
    else $error("warning code outside the warning range");
  a_invalid_zero: assert property (!warn_code_valid_o |-> warn_code_o == 12'h000)
    else $error("warning code shown while not valid");
endmodule // dwm_chk
`default_nettype wire

// >>> sim/dwm_top_tb.sv
// Purpose: self-checking bench of the drive warning manager.
// Assumes: settings at reset: general detect on, mask off, code output both.
// Notes:   ripple compare runs against a zero drive-side copy.
`default_nettype none
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end

// ==========================================================================
// bench top
module dwm_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i, rst_n_i, we_i, re_i, servo_on, cdv, h_go;
  logic [7:0]  addr_i;
  logic [31:0] wdata_i, dev, cdata;
  logic [3:0]  h_op;
  logic [9:0]  cond;
  logic [15:0] oh;
  logic [31:0] rip;
  logic        rv;
  wire         batt_alm, vib_alm;
  wire  [13:0] pulse;
  wire  [31:0] rdata, cl_data;
  wire  [11:0] code;
  wire         cl_valid, code_valid, any_w;
  int          miscompares, tests_run;
  logic [11:0] hcode [0:11] = '{12'h94a, 12'h94b, 12'h94c, 12'h94d, 12'h94e, 12'h95a,
                                12'h95b, 12'h95d, 12'h95e, 12'h95f, 12'h97a, 12'h960};
  logic [11:0] ccode [0:6] = '{12'h910, 12'h920, 12'h921, 12'h912, 12'h913, 12'h923, 12'h930};

  dwm_host i_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .op_i(h_op), .go_i(h_go), .pulse_o(pulse));
  dwm_top i_dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .we_i(we_i),
    .re_i(re_i), .rdata_o(rdata), .deviation_i(dev), .servo_on_i(servo_on),
    .overload_pre_i(cond[0]), .regen_pre_i(cond[1]), .dbrake_pre_i(cond[2]),
    .vib_detect_i(cond[7]), .overheat_protection_input_i(oh),
    .enc_ripple_i(rip), .drv_ripple_i(32'h00000000), .ripple_valid_i(rv),
    .ctrl_temp_bad_i(cond[3]), .power_temp_bad_i(cond[4]), .fan_stopped_i(cond[5]),
    .battery_low_i(cond[6]), .overtravel_i(cond[8]), .part_life_end_i(cond[9]),
    .err_param_num_i(pulse[0]), .err_range_i(pulse[1]), .err_calc_i(pulse[2]),
    .err_size_i(pulse[3]), .err_latch_mode_i(pulse[4]), .cmd_unmet_i(pulse[5]),
    .cmd_unsupported_i(pulse[6]), .cmd_latch_interf_i(pulse[7]),
    .cmd_sub_conflict_i(pulse[8]), .cmd_undefined_i(pulse[9]), .cmd_phase_err_i(pulse[10]),
    .link_error_i(pulse[11]), .cmd_ok_i(pulse[12]), .clear_fault_i(pulse[13]),
    .cmd_data_i(cdata), .cmd_data_valid_i(cdv), .clamped_data_o(cl_data),
    .clamped_valid_o(cl_valid), .warn_code_o(code), .warn_code_valid_o(code_valid),
    .warn_any_o(any_w), .battery_alarm_o(batt_alm), .vibration_alarm_o(vib_alm)
  );

  // 250 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  // ========================================================================
  // bus and host tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    we_i <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1;
    `CHK("register read", e, rdata)
  endtask
  task automatic host(input logic [3:0] op);
    @(posedge clk_i);
    h_op <= op;
    h_go <= 1'b1;
    @(posedge clk_i);
    h_go <= 1'b0;
    repeat (4) @(posedge clk_i);
  endtask
  // two edges let a raise or clear reach the registered code first
  task automatic chk(input logic v, input logic [11:0] c);
    repeat (2) @(posedge clk_i);
    #1;
    `CHK("code valid", v, code_valid)
    `CHK("warning code", c, code)
  endtask
  task automatic raise(input int i);
    @(posedge clk_i);
    cond <= 10'h001 << i;
    repeat (4) @(posedge clk_i);
    cond <= 10'h000;
  endtask

  // ========================================================================
  // scenarios
  task automatic t_regs;
    rd(8'h14, 32'h0000010b);
    rd(8'h04, 32'h00000064);
    rd(8'h1c, 32'hffffffff);
    rd(8'h3c, 32'h00000000);
    $display("test registers done");
  endtask
  task automatic t_cmd;
    for (int i = 0; i < 12; i++) begin
      host(4'(i));
      chk(1'b1, hcode[i]);
      host(4'd12);
      if (i == 4 || i == 11) begin
        chk(1'b1, hcode[i]);
        host(4'd13);
      end
      chk(1'b0, 12'h000);
    end
    $display("test commands done");
  endtask
  task automatic t_legacy;
    wr(8'h14, 32'h0000030b);
    host(4'd1);
    host(4'd12);
    chk(1'b1, 12'h94b);
    wr(8'h20, 32'h00000001);
    chk(1'b0, 12'h000);
    wr(8'h14, 32'h0000012b);
    host(4'd1);
    host(4'd11);
    chk(1'b0, 12'h000);
    wr(8'h14, 32'h0000000b);
    host(4'd1);
    chk(1'b0, 12'h000);
    `CHK("any warning", 1'b1, any_w)
    host(4'd12);
    wr(8'h14, 32'h0000010b);
    $display("test profile mask and code output done");
  endtask
  task automatic t_prio;
    host(4'd11);
    host(4'd1);
    chk(1'b1, 12'h94b);
    rd(8'h28, 32'h0000194b);
    rd(8'h24, 32'h00402000);
    host(4'd12);
    chk(1'b1, 12'h960);
    host(4'd13);
    chk(1'b0, 12'h000);
    $display("test priority done");
  endtask
  task automatic t_dev;
    wr(8'h00, 32'h000003e8);
    wr(8'h04, 32'h00000032);
    wr(8'h08, 32'h00000064);
    wr(8'h0c, 32'h0000000a);
    @(posedge clk_i);
    dev <= 32'h000001f4;
    chk(1'b0, 12'h000);
    @(posedge clk_i);
    dev <= 32'h000001f5;
    chk(1'b1, 12'h900);
    @(posedge clk_i);
    dev <= 32'h00000000;
    chk(1'b1, 12'h900);
    host(4'd13);
    @(posedge clk_i);
    dev <= 32'h0000000b;
    servo_on <= 1'b1;
    chk(1'b1, 12'h901);
    @(posedge clk_i);
    servo_on <= 1'b0;
    dev <= 32'h00000000;
    host(4'd13);
    chk(1'b0, 12'h000);
    $display("test deviation done");
  endtask
  task automatic t_cond;
    for (int i = 0; i < 7; i++) begin
      raise(i);
      chk(1'b1, ccode[i]);
      host(4'd13);
      chk(1'b0, 12'h000);
    end
    wr(8'h14, 32'h00000109);
    raise(0);
    chk(1'b0, 12'h000);
    raise(5);
    chk(1'b1, 12'h923);
    host(4'd13);
    // alarm routing: battery and vibration both as alarms
    wr(8'h14, 32'h0000010a);
    @(posedge clk_i);
    cond <= 10'h0c0;
    repeat (4) @(posedge clk_i);
    #1;
    `CHK("battery alarm", 1'b1, batt_alm)
    `CHK("vibration alarm", 1'b1, vib_alm)
    @(posedge clk_i);
    cond <= 10'h000;
    chk(1'b0, 12'h000);
    // vibration, overtravel and maintenance as warnings
    wr(8'h14, 32'h000001df);
    raise(7);
    chk(1'b1, 12'h911);
    host(4'd13);
    @(posedge clk_i);
    servo_on <= 1'b1;
    raise(8);
    chk(1'b1, 12'h9a0);
    host(4'd13);
    raise(9);
    chk(1'b1, 12'h9b0);
    host(4'd13);
    @(posedge clk_i);
    servo_on <= 1'b0;
    rip <= 32'h00000001;
    rv <= 1'b1;
    chk(1'b1, 12'h942);
    @(posedge clk_i);
    rv <= 1'b0;
    host(4'd13);
    chk(1'b0, 12'h000);
    wr(8'h10, 32'h00000100);
    @(posedge clk_i);
    oh <= 16'h0100;
    chk(1'b0, 12'h000);
    @(posedge clk_i);
    oh <= 16'h0101;
    chk(1'b1, 12'h93b);
    @(posedge clk_i);
    oh <= 16'h0000;
    host(4'd13);
    chk(1'b0, 12'h000);
    wr(8'h14, 32'h0000010b);
    $display("test conditions done");
  endtask
  task automatic t_clamp;
    wr(8'h18, 32'h0000000a);
    wr(8'h1c, 32'h00000014);
    @(posedge clk_i);
    cdata <= 32'h00000005;
    cdv <= 1'b1;
    @(posedge clk_i);
    cdata <= 32'h0000001e;
    #1;
    `CHK("clamp low", 33'h10000000a, {cl_valid, cl_data})
    @(posedge clk_i);
    cdv <= 1'b0;
    #1;
    `CHK("clamp high", 33'h100000014, {cl_valid, cl_data})
    chk(1'b1, 12'h97b);
    host(4'd12);
    chk(1'b0, 12'h000);
    $display("test clamp done");
  endtask

  // ========================================================================
  // verdict
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // a hang counts as a mismatch
  initial begin
    #400000;
    miscompares++;
    $display("CHECK FAILED run time expected %h seen %h", 1'b0, 1'b1);
    test_done;
  end

  // main sequence
  initial begin
    {rst_n_i, we_i, re_i, servo_on, cdv, h_go} = 6'h00;
    {addr_i, wdata_i, dev, cdata, h_op, cond, oh, rip, rv} = '0;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    t_regs;
    t_cmd;
    t_legacy;
    t_prio;
    t_dev;
    t_cond;
    t_clamp;
    test_done;
  end
endmodule // dwm_top_tb

bind dwm_top dwm_chk i_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .we_i(we_i), .cmd_ok_i(cmd_ok_i),
  .clear_fault_i(clear_fault_i), .cmd_data_i(cmd_data_i), .cmd_data_valid_i(cmd_data_valid_i),
  .clamped_data_o(clamped_data_o), .clamped_valid_o(clamped_valid_o),
  .warn_code_o(warn_code_o), .warn_code_valid_o(warn_code_valid_o), .warn_any_o(warn_any_o)
);
`default_nettype wire
